// ==== shared/dlc_pkg.sv ====
// Purpose: constants for the data-link control block
// Assumes: classic wishbone, 32-bit data, 8-bit registers in low lanes
// Notes:   offsets are byte addresses of aligned words
package dlc_pkg;
  localparam logic [7:0] DLC_CTRL_OFS    = 8'h00;
  localparam logic [7:0] DLC_STAT_OFS    = 8'h04;
  localparam logic [7:0] DLC_TXD_OFS     = 8'h08;
  localparam logic [7:0] DLC_RXD_OFS     = 8'h0c;
  localparam logic [7:0] DLC_CTRL_RESET  = 8'h00;
  localparam int         BIT_TYPE_SEL    = 0;
  localparam int         BIT_TX_CHECK    = 1;
  localparam int         BIT_FORCE_IDLE  = 2;
  localparam int         BIT_FORCE_ABORT = 3;
  localparam int         BIT_DUP_DISCARD = 4;
  localparam int         BIT_RX_CHK_DIS  = 5;
  localparam int         BIT_AUTO_ABORT_DIS = 6;
  localparam int         BIT_ALT_FORMAT  = 7;
  localparam logic [7:0] DLC_FLAG        = 8'h7e;
  localparam logic [7:0] DLC_ABORT       = 8'hfe;
  localparam logic [7:0] DLC_ONES        = 8'hff;
  localparam logic [15:0] DLC_CRC_INIT   = 16'hffff;
  localparam logic [15:0] DLC_CRC_POLY   = 16'h8408;
  localparam logic [15:0] DLC_CRC_GOOD   = 16'hf0b8;
  localparam logic [2:0] DLC_LAST_BIT    = 3'h7;
  typedef enum logic [1:0] {
    DLC_FMT_SF, DLC_FMT_ALT96, DLC_FMT_ESF, DLC_FMT_OTHER
  } dlc_fmt_e;
  typedef enum {
    DLC_TX_FLAG, DLC_TX_DATA, DLC_TX_CRC_LO, DLC_TX_CRC_HI, DLC_TX_ABORT
  } dlc_tx_state_e;
endpackage : dlc_pkg

// ==== src/dlc_crc16.sv ====
// Purpose: one-bit step of the link frame check (reflected crc16)
// Assumes: lsb-first bit stream
// Notes:   combinational, shared by both directions
`timescale 1ns/100ps
module dlc_crc16
  import dlc_pkg::*;
(
  input  wire logic [15:0] crc_in,
  input  wire logic        bit_in,
  output logic      [15:0] crc_out
);
  wire feedback = crc_in[0] ^ bit_in;
  assign crc_out = (crc_in >> 1) ^ (feedback ? DLC_CRC_POLY : 16'h0000);
endmodule : dlc_crc16

// ==== src/dlc_rx_check.sv ====
// Purpose: receive side: frame check and duplicate discard
// Assumes: receive bits and bit enable come from the framer
// Notes:   duplicates compared on the final check register value only
`timescale 1ns/100ps
module dlc_rx_check
  import dlc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       rx_bit_en,
  input  wire logic       rx_bit,
  input  wire logic       rx_frame_end,
  input  wire logic       check_disable,
  input  wire logic       dup_discard,
  output logic            rx_accept_reg,
  output logic            rx_reject_reg,
  output logic      [7:0] rx_last_reg
);
  logic [15:0] crc_reg;
  logic [15:0] held_crc_reg;
  logic [15:0] crc_step;
  logic [7:0]  shift_reg;
  logic        held_valid_reg;
  wire crc_ok   = check_disable || (crc_reg == DLC_CRC_GOOD);
  wire is_dup   = dup_discard && held_valid_reg && (crc_reg == held_crc_reg);
  wire accept   = rx_frame_end && crc_ok && !is_dup;

  dlc_crc16 u_crc (.crc_in(crc_reg), .bit_in(rx_bit), .crc_out(crc_step));

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      crc_reg        <= DLC_CRC_INIT;
      held_crc_reg   <= DLC_CRC_INIT;
      shift_reg      <= 8'h00;
      held_valid_reg <= 1'b0;
      rx_accept_reg  <= 1'b0;
      rx_reject_reg  <= 1'b0;
      rx_last_reg    <= 8'h00;
    end else begin
      rx_accept_reg <= accept;
      rx_reject_reg <= rx_frame_end && !accept;
      if (rx_frame_end) begin
        crc_reg <= DLC_CRC_INIT;
        if (accept) begin
          held_crc_reg   <= crc_reg; // see (RULE6)
          held_valid_reg <= 1'b1;
          rx_last_reg    <= shift_reg;
        end
      end else if (rx_bit_en) begin
        crc_reg   <= crc_step; // see (RULE5)
        shift_reg <= {rx_bit, shift_reg[7:1]};
      end
    end
  end

  chk_skip_a: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE5)
    (rx_frame_end && check_disable && !is_dup) |=> rx_accept_reg)
    else $error("frame refused with check disabled");
  dup_drop_a: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE6)
    (rx_frame_end && is_dup) |=> (rx_reject_reg && !rx_accept_reg))
    else $error("duplicate frame accepted");
endmodule : dlc_rx_check

// ==== src/dlc_link_ctrl.sv ====
// Purpose: data-link control register and first hdlc transmit/receive pair
// Assumes: link bit enable pulses from the framer's t1 bit timing
// Notes:   one octet of transmit data held at a time, no buffer
`timescale 1ns/100ps
// Summary of operation
// (RULE1) bit 7 selects alternate 96-frame link format, else superframe bits
// (RULE2) alternate format honoured only in 96-frame or extended framing
// (RULE3) bit 6 clear: abort sent on abrupt message-to-bit switch
// (RULE4) bit 6 set: no abort on that switch
// (RULE5) bit 5 clear checks receive frame check, set skips it
// (RULE6) bit 4 set discards received frames equal to the held one; the code compares only the final check register values
// (RULE7) bit 3 set sends continuous ones as abort
// (RULE8) flags 7e sent whenever no message is waiting
// (RULE9) bit 2 set forces continuous flags, suppressing pending messages
// (RULE10) forced idle ignored in bit-oriented mode
// (RULE11) bit 0 selects bit-oriented (0) or message-oriented (1) transmit
// (RULE12) bit 1 appends frame check in message mode only
// (RULE13) after forced abort or idle, resume flags on an octet boundary
module dlc_link_ctrl
  import dlc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  input  wire logic [1:0]  framing_format,
  input  wire logic        tx_bit_en,
  input  wire logic        tx_msg_end,
  input  wire logic        bit_msg_bit,
  input  wire logic        rx_bit_en,
  input  wire logic        rx_bit,
  input  wire logic        rx_frame_end,
  output logic             tx_bit_reg,
  output logic             alt_format_active_reg,
  output logic             superframe_bits_reg,
  output logic             rx_accept_reg,
  output logic             rx_reject_reg
);
  logic [7:0]    ctrl_reg;
  logic [7:0]    txd_reg;
  logic          txd_full_reg;
  logic [7:0]    tx_sh_reg;
  logic [2:0]    bit_cnt_reg;
  logic [15:0]   tx_crc_reg;
  logic [15:0]   tx_crc_step;
  logic [2:0]    ones_reg;
  logic          stuff_reg;
  logic          prev_mos_reg;
  logic          tx_in_msg_reg;
  logic [7:0]    rx_last;
  dlc_tx_state_e tx_state_reg;
  dlc_tx_state_e tx_state_next;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] o);
    addr_hit = (a == o);
  endfunction : addr_hit

  // bus decode
  wire req      = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire hit_ctrl = addr_hit(wb_adr_i, DLC_CTRL_OFS);
  wire hit_stat = addr_hit(wb_adr_i, DLC_STAT_OFS);
  wire hit_txd  = addr_hit(wb_adr_i, DLC_TXD_OFS);
  wire hit_rxd  = addr_hit(wb_adr_i, DLC_RXD_OFS);
  wire mapped   = hit_ctrl || hit_stat || hit_txd || hit_rxd;
  wire wr_lane0 = req && wb_we_i && wb_sel_i[0];
  wire wr_ctrl  = wr_lane0 && hit_ctrl;
  wire wr_txd   = wr_lane0 && hit_txd;

  // control fields
  wire sel_mos      = ctrl_reg[BIT_TYPE_SEL];
  wire tx_check     = ctrl_reg[BIT_TX_CHECK] && sel_mos; // see (RULE12)
  wire force_idle   = ctrl_reg[BIT_FORCE_IDLE] && sel_mos; // see (RULE10)
  wire force_abort  = ctrl_reg[BIT_FORCE_ABORT];
  wire auto_abort_n = ctrl_reg[BIT_AUTO_ABORT_DIS]; // see (RULE4)
  wire fmt_ok       = (framing_format == DLC_FMT_ALT96) ||
                      (framing_format == DLC_FMT_ESF);
  wire alt_on       = ctrl_reg[BIT_ALT_FORMAT] && fmt_ok; // see (RULE2)

  // abrupt switch: message frame in flight and software selects bit mode
  wire abrupt       = prev_mos_reg && !sel_mos && tx_in_msg_reg;
  wire auto_abort   = abrupt && !auto_abort_n; // see (RULE3)
  wire in_data      = (tx_state_reg == DLC_TX_DATA) ||
                      (tx_state_reg == DLC_TX_CRC_LO) ||
                      (tx_state_reg == DLC_TX_CRC_HI);
  // a zero goes out after every run of five ones; the shifter holds still
  wire stuff_w      = in_data && (ones_reg == 3'h5) && !stuff_reg;
  wire octet_edge   = tx_bit_en && (bit_cnt_reg == DLC_LAST_BIT) && !stuff_w;
  wire raw_bit      = stuff_w ? 1'b0 : tx_sh_reg[0];
  // an abort octet owns the line even after bit mode is selected
  wire shifter_out  = sel_mos || (tx_state_reg == DLC_TX_ABORT);
  wire line_bit     = force_abort ? 1'b1 : // see (RULE7)
                      (shifter_out ? raw_bit : bit_msg_bit);

  dlc_crc16 u_tx_crc (
    .crc_in (tx_crc_reg),
    .bit_in (tx_sh_reg[0]),
    .crc_out(tx_crc_step)
  );

  // next state at each octet boundary
  always_comb begin
    tx_state_next = tx_state_reg;
    case (tx_state_reg)
      DLC_TX_FLAG:   tx_state_next = (txd_full_reg && !force_idle) ?
                                     DLC_TX_DATA : DLC_TX_FLAG; // see (RULE9)
      DLC_TX_DATA:   tx_state_next = force_idle ? DLC_TX_FLAG :
                                     (txd_full_reg ? DLC_TX_DATA :
                                     (tx_check ? DLC_TX_CRC_LO :
                                     DLC_TX_FLAG));
      DLC_TX_CRC_LO: tx_state_next = force_idle ? DLC_TX_FLAG :
                                     DLC_TX_CRC_HI; // see (RULE9)
      DLC_TX_CRC_HI: tx_state_next = DLC_TX_FLAG;
      DLC_TX_ABORT:  tx_state_next = DLC_TX_FLAG; // see (RULE13)
      default:       tx_state_next = DLC_TX_FLAG;
    endcase
  end

  wire [7:0] load_octet =
    (tx_state_next == DLC_TX_DATA)   ? txd_reg :
    (tx_state_next == DLC_TX_CRC_LO) ? ~tx_crc_reg[7:0] :
    (tx_state_next == DLC_TX_CRC_HI) ? ~tx_crc_reg[15:8] :
                                       DLC_FLAG; // see (RULE8)

  // register bus
  wire [31:0] rd_data =
    hit_ctrl ? {24'h000000, ctrl_reg} :
    hit_stat ? {26'h0000000, alt_on, tx_in_msg_reg, txd_full_reg,
                force_abort, rx_reject_reg, rx_accept_reg} :
    hit_rxd  ? {24'h000000, rx_last} : 32'h00000000;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl_reg <= DLC_CTRL_RESET;
    end else begin
      wb_ack_o <= req && mapped;
      wb_err_o <= req && !mapped;
      wb_dat_o <= (req && !wb_we_i) ? rd_data : 32'h00000000;
      if (wr_ctrl)
        ctrl_reg <= wb_dat_i[7:0]; // see (RULE11)
    end
  end

  // transmit data holding octet; a new write wins over the consume
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      txd_reg      <= 8'h00;
      txd_full_reg <= 1'b0;
    end else if (wr_txd) begin
      txd_reg      <= wb_dat_i[7:0];
      txd_full_reg <= 1'b1;
    end else if (force_idle || (octet_edge && !force_abort &&
                 tx_state_next == DLC_TX_DATA)) begin
      txd_full_reg <= 1'b0; // see (RULE9)
    end
  end

  // transmit serialiser
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tx_state_reg  <= DLC_TX_FLAG;
      tx_sh_reg     <= DLC_FLAG;
      bit_cnt_reg   <= 3'h0;
      tx_crc_reg    <= DLC_CRC_INIT;
      ones_reg      <= 3'h0;
      stuff_reg     <= 1'b0;
      prev_mos_reg  <= 1'b0;
      tx_in_msg_reg <= 1'b0;
      tx_bit_reg    <= 1'b1;
    end else if (tx_bit_en) begin
      tx_bit_reg   <= line_bit;
      prev_mos_reg <= sel_mos;
      if (force_abort) begin
        tx_state_reg  <= DLC_TX_ABORT; // see (RULE7)
        tx_in_msg_reg <= 1'b0;
        tx_crc_reg    <= DLC_CRC_INIT;
        ones_reg      <= 3'h0;
        stuff_reg     <= 1'b0;
        bit_cnt_reg   <= 3'h0;
        tx_sh_reg     <= DLC_FLAG;
      end else if (abrupt) begin
        // the frame is dropped at once; with auto abort on, bit mode waits for the abort octet
        tx_in_msg_reg <= 1'b0;
        tx_state_reg  <= auto_abort ? DLC_TX_ABORT : DLC_TX_FLAG;
        bit_cnt_reg   <= 3'h0;
        tx_crc_reg    <= DLC_CRC_INIT;
        tx_sh_reg     <= auto_abort ? DLC_ABORT : DLC_FLAG; // see (RULE3)
      end else if (stuff_w) begin
        stuff_reg <= 1'b1;
        ones_reg  <= 3'h0;
      end else begin
        stuff_reg <= 1'b0;
        ones_reg  <= (in_data && tx_sh_reg[0]) ? ones_reg + 3'h1 : 3'h0;
        if (in_data && tx_state_reg == DLC_TX_DATA)
          tx_crc_reg <= tx_crc_step;
        if (bit_cnt_reg == DLC_LAST_BIT) begin
          bit_cnt_reg   <= 3'h0;
          tx_state_reg  <= tx_state_next; // see (RULE13)
          tx_sh_reg     <= load_octet;
          tx_in_msg_reg <= (tx_state_next != DLC_TX_FLAG);
          if (tx_state_next == DLC_TX_FLAG)
            tx_crc_reg <= DLC_CRC_INIT;
        end else begin
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          tx_sh_reg   <= {1'b1, tx_sh_reg[7:1]};
        end
      end
    end
  end

  // format control
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      alt_format_active_reg <= 1'b0;
      superframe_bits_reg   <= 1'b1;
    end else begin
      alt_format_active_reg <= alt_on; // see (RULE1)
      superframe_bits_reg   <= !alt_on; // see (RULE1)
    end
  end

  dlc_rx_check u_rx (
    .clk          (clk),
    .reset_n      (reset_n),
    .rx_bit_en    (rx_bit_en),
    .rx_bit       (rx_bit),
    .rx_frame_end (rx_frame_end),
    .check_disable(ctrl_reg[BIT_RX_CHK_DIS]),
    .dup_discard  (ctrl_reg[BIT_DUP_DISCARD]),
    .rx_accept_reg(rx_accept_reg),
    .rx_reject_reg(rx_reject_reg),
    .rx_last_reg  (rx_last)
  );

  sequence abort_req_s;
    tx_bit_en && force_abort;
  endsequence
  sequence ones_out_s;
    ##1 tx_bit_reg;
  endsequence

  abort_ones_a: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE7)
    abort_req_s |-> ones_out_s)
    else $error("forced abort did not send a one");
  alt_gate_a: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE2)
    !fmt_ok |=> !alt_format_active_reg)
    else $error("alternate format active in wrong framing");
  alt_on_a: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE1)
    alt_on |=> (alt_format_active_reg && !superframe_bits_reg))
    else $error("alternate format not applied");
  idle_stop_a: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE9)
    (force_idle && octet_edge && !force_abort && !abrupt) |=>
      tx_state_reg == DLC_TX_FLAG && tx_sh_reg == DLC_FLAG)
    else $error("forced idle sent data");
  idle_bos_a: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE10)
    (!sel_mos && tx_bit_en && !force_abort && !shifter_out) |=>
      tx_bit_reg == $past(bit_msg_bit))
    else $error("bit mode output wrong");
  auto_abort_a: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE3)
    (tx_bit_en && auto_abort && !force_abort) |=>
      (tx_sh_reg == DLC_ABORT && tx_state_reg == DLC_TX_ABORT))
    else $error("no abort on switch");
  no_abort_a: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE4)
    (tx_bit_en && abrupt && auto_abort_n && !force_abort) |=>
      tx_sh_reg == DLC_FLAG)
    else $error("abort sent while disabled");
  crc_off_a: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE12)
    (octet_edge && !force_abort && !abrupt && !tx_check &&
     tx_state_reg == DLC_TX_DATA) |=> tx_state_reg != DLC_TX_CRC_LO)
    else $error("check octets appended when off");
  resume_a: assert property (@(posedge clk) disable iff (!reset_n) // see (RULE13)
    (tx_bit_en && !force_abort && !abrupt &&
     tx_state_reg == DLC_TX_ABORT && bit_cnt_reg == DLC_LAST_BIT) |=>
      (tx_state_reg == DLC_TX_FLAG && tx_sh_reg == DLC_FLAG))
    else $error("abort exit off octet boundary");
endmodule : dlc_link_ctrl

// ==== tb/dlc_remote_model.sv ====
// Purpose: remote terminal on the t1 data link, line side of the block
// Assumes: one transmit bit every four clocks, receive bits destuffed
// Notes:   rx_bit shows the inverse of the last bit outside a bit slot
`timescale 1ns/100ps
module dlc_remote_model (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        tx_bit_reg,
  output logic             tx_bit_en,
  output logic             rx_bit_en,
  output logic             rx_bit,
  output logic             rx_frame_end,
  output logic      [15:0] tx_window,
  output int               tx_count
);
  logic [1:0] div_reg;
  logic       take_reg;
  initial begin
    rx_bit_en    = 1'b0;
    rx_bit       = 1'b0;
    rx_frame_end = 1'b0;
  end
  assign tx_bit_en = reset_n && (div_reg == 2'h0);
  // tx_bit_reg settles one cycle after the enable, so sample it then
  always @(posedge clk) begin
    div_reg  <= reset_n ? div_reg + 2'h1 : 2'h0;
    take_reg <= tx_bit_en;
    if (!reset_n) begin
      tx_count <= 0;
    end else if (take_reg) begin
      tx_window <= {tx_bit_reg, tx_window[15:1]};
      tx_count  <= tx_count + 1;
    end
  end
  // octets go out lsb first, with check octets counted as payload
  task automatic send_frame(input logic [23:0] d);
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      rx_bit_en <= 1'b1;
      rx_bit    <= d[i];
      @(posedge clk);
      rx_bit_en <= 1'b0;
      rx_bit    <= ~d[i];
    end
    @(posedge clk);
    rx_frame_end <= 1'b1;
    @(posedge clk);
    rx_frame_end <= 1'b0;
  endtask : send_frame
endmodule : dlc_remote_model

// ==== tb/test_t1_data_link_hdlc_control.sv ====
// Purpose: self-checking bench for the data-link control block
// Assumes: read and receive results are noted in a queue ahead of time
// Notes:   line checks look at the last sixteen transmitted bits
`timescale 1ns/100ps
module test_t1_data_link_hdlc_control
  import dlc_pkg::*;
;
  logic        clk, reset_n, cyc, stb, we, msg_bit, ack, err;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  logic [1:0]  fmt;
  logic        tbe, rbe, rb, rfe, txb, alt, sfb, acc, rej;
  logic [15:0] win;
  int          tcnt, failures, cmp_count;
  logic [32:0] exp_q[$];
  logic [23:0] frm;

  dlc_link_ctrl dut_u (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .framing_format(fmt), .tx_bit_en(tbe), .tx_msg_end(1'b0),
    .bit_msg_bit(msg_bit), .rx_bit_en(rbe), .rx_bit(rb),
    .rx_frame_end(rfe), .tx_bit_reg(txb), .alt_format_active_reg(alt),
    .superframe_bits_reg(sfb), .rx_accept_reg(acc), .rx_reject_reg(rej));
  dlc_remote_model far_u (.clk(clk), .reset_n(reset_n), .tx_bit_reg(txb),
    .tx_bit_en(tbe), .rx_bit_en(rbe), .rx_bit(rb), .rx_frame_end(rfe),
    .tx_window(win), .tx_count(tcnt));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [32:0] e, input logic [32:0] a);
    cmp_count++;
    if (a !== e) begin
      failures++;
      $display("[FAIL] %0t exp %h got %h", $time, e, a);
    end
  endtask : chk

  function automatic logic is_flags(input logic [15:0] w);
    logic hit;
    hit = 1'b0;
    for (int r = 0; r < 8; r++) begin
      hit |= (8'({w[7:0], w[7:0]} >> r) == DLC_FLAG);
    end
    return hit && (w[15:8] === w[7:0]);
  endfunction : is_flags

  // a zero then seven ones, oldest bit lowest in the window
  function automatic logic has_abort(input logic [15:0] w);
    logic hit;
    hit = 1'b0;
    for (int r = 0; r < 9; r++) begin
      hit |= (w[r +: 8] === DLC_ABORT);
    end
    return hit;
  endfunction : has_abort

  // ack or err is sampled at the edge, never assumed after a fixed count
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] s);
    int n;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(ack === 1'b1 || err === 1'b1) && n < 50);
    if (n >= 50) begin
      failures++;
      stop_test();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 8'h00, 4'h1);
  endtask : rd

  task automatic wait_bits(input int n);
    int s, k;
    s = tcnt;
    k = 0;
    while (tcnt - s < n && k < 2000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 2000) begin
      failures++;
      stop_test();
    end
  endtask : wait_bits

  task automatic rx_case(input logic [7:0] c, input logic [1:0] e);
    wb(1'b1, DLC_CTRL_OFS, c, 4'h1);
    exp_q.push_back({31'h0, e});
    far_u.send_frame(frm);
    repeat (4) @(posedge clk);
  endtask : rx_case

  always @(posedge clk) begin
    if ((ack === 1'b1 && !we) || err === 1'b1 || acc === 1'b1 || rej === 1'b1)
    begin
      if (exp_q.size() == 0) chk(33'h0, 33'h1_ffff_ffff);
      else if (acc === 1'b1 || rej === 1'b1) chk(exp_q.pop_front(), {31'h0, rej, acc});
      else chk(exp_q.pop_front(), {err, err ? 32'h0 : rdat});
    end
  end

  initial begin
    {cyc, stb, we, msg_bit, adr, sel, wdat, fmt} = '0;
    failures = 0;
    cmp_count = 0;
    reset_n = 1'b0;
    void'($urandom(69));
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(DLC_CTRL_OFS, {25'h0, DLC_CTRL_RESET});
    rd(8'h10, 33'h1_0000_0000);
    wb(1'b1, DLC_CTRL_OFS, 8'hff, 4'h0);
    rd(DLC_CTRL_OFS, {25'h0, DLC_CTRL_RESET});
    for (int f = 0; f < 4; f++) begin
      fmt <= f[1:0];
      wb(1'b1, DLC_CTRL_OFS, 8'h80, 4'h1);
      repeat (2) @(posedge clk);
      chk(f == 1 || f == 2, alt);
      chk(!(f == 1 || f == 2), sfb);
    end
    wb(1'b1, DLC_CTRL_OFS, 8'h00, 4'h1);
    repeat (2) @(posedge clk);
    chk(33'h1, sfb);
    wb(1'b1, DLC_CTRL_OFS, 8'h01, 4'h1);
    wait_bits(24);
    chk(1'b1, is_flags(win));
    wb(1'b1, DLC_CTRL_OFS, 8'h05, 4'h1);
    wb(1'b1, DLC_TXD_OFS, 8'h01 + 8'($urandom_range(0, 100)), 4'h1);
    wait_bits(32);
    chk(1'b1, is_flags(win));
    wb(1'b1, DLC_CTRL_OFS, 8'h09, 4'h1);
    wait_bits(24);
    chk(16'hffff, win);
    wb(1'b1, DLC_CTRL_OFS, 8'h01, 4'h1);
    wait_bits(32);
    chk(1'b1, is_flags(win));
    wb(1'b1, DLC_CTRL_OFS, 8'h04, 4'h1);
    wait_bits(24);
    chk(16'h0000, win);
    wb(1'b1, DLC_CTRL_OFS, 8'h03, 4'h1);
    wb(1'b1, DLC_TXD_OFS, 8'h00, 4'h1);
    wait_bits(12);
    wb(1'b1, DLC_CTRL_OFS, 8'h00, 4'h1);
    wait_bits(12);
    chk(1'b1, has_abort(win));
    wb(1'b1, DLC_CTRL_OFS, 8'h43, 4'h1);
    wb(1'b1, DLC_TXD_OFS, 8'h00, 4'h1);
    wait_bits(12);
    wb(1'b1, DLC_CTRL_OFS, 8'h40, 4'h1);
    wait_bits(12);
    chk(1'b0, has_abort(win));
    frm = 24'($urandom());
    rx_case(8'h00, 2'b10);
    rx_case(8'h20, 2'b01);
    rx_case(8'h30, 2'b10);
    rx_case(8'h20, 2'b01);
    rd(DLC_RXD_OFS, {25'h0, frm[23:16]});
    if (exp_q.size() != 0) failures++;
    stop_test();
  end
endmodule : test_t1_data_link_hdlc_control
